// ==== core/motor_param_power_loss_restart.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motor_consts.svh"
module motor_param_power_loss_restart #(
   parameter int unsigned DELAY_STEP_CYC = `DELAY_STEP_MS * `MCLK_KHZ,
   parameter int unsigned RUN_WAIT_CYC   = `RUN_WAIT_MS * `MCLK_KHZ
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    ce,
   input  wire logic [15:0]             hr_addr,
   input  wire logic                    hr_wr,
   input  wire logic                    hr_rd,
   input  wire logic [15:0]             hr_wdata,
   output var  logic [15:0]             hr_rdata,
   output var  logic                    hr_ack,
   output var  logic                    hr_err,
   input  wire logic                    dc_undervolt,
   input  wire logic                    power_ready,
   input  wire logic                    run_cmd,
   input  wire logic [15:0]             dc_link_volts,
   input  wire logic [15:0]             output_freq,
   input  wire logic                    decel_done,
   input  wire logic                    alarm_clear,
   input  wire logic                    tune_done,
   input  wire motor_pkg::tune_result_t tune_result,
   output var  logic                    drive_en,
   output var  logic                    decel_req,
   output var  logic                    restart_pulse,
   output var  logic [15:0]             restart_freq,
   output var  logic                    undervoltage_alarm,
   output var  logic                    tune_start,
   output var  logic                    tune_busy,
   output var  motor_pkg::motor_params_t params
);
   logic                    rst_meta_r;
   logic                    rst_sync_r;
   logic [2:0]              pin_meta_r;
   logic [2:0]              pin_sync_r;
   logic                    uv;
   logic                    pwr_ok;
   logic                    run;
   motor_pkg::motor_params_t prm_r;
   motor_pkg::loss_state_t  state_r;
   motor_pkg::loss_state_t  state_nxt;
   logic [31:0]             pre_r;
   logic [15:0]             ticks_r;
   logic [31:0]             win_r;
   logic                    delay_done;
   logic [15:0]             saved_freq_r;
   logic                    hw_tune_r;
   // legal value ranges per holding register
   function automatic logic wr_legal(input logic [15:0] a, input logic [15:0] d);
      case (a)
         `RA_CAP:      wr_legal = (d >= `CAP_MIN) && (d <= `CAP_MAX);
         `RA_CUR:      wr_legal = (d <= `CUR_MAX);
         `RA_TUNE:     wr_legal = (d <= `TUNE_MAX);
         `RA_NOLOAD,
         `RA_R1,
         `RA_X:        wr_legal = (d <= `MEAS_MAX);
         `RA_GAIN_DRV,
         `RA_GAIN_BRK: wr_legal = (d <= `GAIN_MAX);
         `RA_RESP:     wr_legal = (d >= `RESP_MIN) && (d <= `RESP_MAX);
         `RA_SLIP:     wr_legal = (d <= `SLIP_MAX);
         `RA_MODE:     wr_legal = (d <= `MODE_MAX) && (d != `MODE_HOLE);
         `RA_START_F:  wr_legal = (d >= `SF_MIN) && (d <= `SF_MAX);
         `RA_DELAY:    wr_legal = (d >= `DLY_MIN) && (d <= `DLY_MAX);
         `RA_CONT_LVL: wr_legal = (d >= `LVL_MIN) && (d <= `LVL_MAX);
         default:      wr_legal = 1'b0;
      endcase
   endfunction
   function automatic logic addr_known(input logic [15:0] a);
      case (a)
         `RA_CAP, `RA_CUR, `RA_TUNE, `RA_NOLOAD, `RA_R1, `RA_X, `RA_GAIN_DRV,
         `RA_RESP, `RA_GAIN_BRK, `RA_SLIP, `RA_MODE, `RA_START_F, `RA_DELAY,
         `RA_CONT_LVL:
            addr_known = 1'b1;
         default:
            addr_known = 1'b0;
      endcase
   endfunction
   logic wr_ok;
   assign wr_ok = hr_wr && wr_legal(hr_addr, hr_wdata);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   logic arst_n;
   assign arst_n = rst_sync_r;
   // pins from the power board are asynchronous to mclk
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end
      else if (ce)
      begin
         pin_meta_r <= {run_cmd, power_ready, dc_undervolt};
         pin_sync_r <= pin_meta_r;
      end
   end
   assign uv     = pin_sync_r[0];
   assign pwr_ok = pin_sync_r[1];
   assign run    = pin_sync_r[2];
   // register bank; tuning results win over a host write in the same cycle
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prm_r.capacity   <= `RST_CAP;
         prm_r.current    <= `RST_CUR;
         prm_r.tune       <= `RST_TUNE;
         prm_r.no_load    <= `RST_NOLOAD;
         prm_r.r1_pct     <= `RST_R1;
         prm_r.x_pct      <= `RST_X;
         prm_r.gain_drv   <= `RST_GAIN;
         prm_r.resp       <= `RST_RESP;
         prm_r.gain_brk   <= `RST_GAIN;
         prm_r.slip       <= `RST_SLIP;
         prm_r.mode       <= `RST_MODE;
         prm_r.start_freq <= `RST_START_F;
         prm_r.delay      <= `RST_DELAY;
         prm_r.cont_level <= `RST_LVL;
      end
      else if (ce)
      begin
         if (wr_ok)
         begin
            case (hr_addr)
               `RA_CAP:      prm_r.capacity   <= hr_wdata;
               `RA_CUR:      prm_r.current    <= hr_wdata;
               `RA_TUNE:     prm_r.tune       <= hr_wdata;
               `RA_NOLOAD:   prm_r.no_load    <= hr_wdata;
               `RA_R1:       prm_r.r1_pct     <= hr_wdata;
               `RA_X:        prm_r.x_pct      <= hr_wdata;
               `RA_GAIN_DRV: prm_r.gain_drv   <= hr_wdata;
               `RA_RESP:     prm_r.resp       <= hr_wdata;
               `RA_GAIN_BRK: prm_r.gain_brk   <= hr_wdata;
               `RA_SLIP:     prm_r.slip       <= hr_wdata;
               `RA_MODE:     prm_r.mode       <= hr_wdata;
               `RA_START_F:  prm_r.start_freq <= hr_wdata;
               `RA_DELAY:    prm_r.delay      <= hr_wdata;
               `RA_CONT_LVL: prm_r.cont_level <= hr_wdata;
               default:      prm_r.capacity   <= prm_r.capacity;
            endcase
         end
         if (tune_done && hw_tune_r)
         begin
            prm_r.no_load <= tune_result.no_load;
            prm_r.r1_pct  <= tune_result.r1_pct;
            prm_r.x_pct   <= tune_result.x_pct;
            prm_r.slip    <= tune_result.slip;
            prm_r.tune    <= `RST_TUNE;
         end
      end
   end
   // writing a one to the trigger launches one measurement run
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hw_tune_r  <= 1'b0;
         tune_start <= 1'b0;
         tune_busy  <= 1'b0;
      end
      else if (ce)
      begin
         tune_start <= 1'b0;
         tune_busy  <= hw_tune_r && !tune_done;
         if (tune_done)
            hw_tune_r <= 1'b0;
         if (wr_ok && (hr_addr == `RA_TUNE) && hr_wdata[0] && !hw_tune_r)
         begin
            hw_tune_r  <= 1'b1;
            tune_start <= 1'b1;
            tune_busy  <= 1'b1;
         end
      end
   end
   // host answer one cycle after the strobe
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hr_rdata <= 16'h0000;
         hr_ack   <= 1'b0;
         hr_err   <= 1'b0;
      end
      else if (ce)
      begin
         hr_ack <= hr_wr || hr_rd;
         hr_err <= (hr_wr && !wr_ok) || (hr_rd && !addr_known(hr_addr));
         if (hr_rd)
         begin
            case (hr_addr)
               `RA_CAP:      hr_rdata <= prm_r.capacity;
               `RA_CUR:      hr_rdata <= prm_r.current;
               `RA_TUNE:     hr_rdata <= prm_r.tune;
               `RA_NOLOAD:   hr_rdata <= prm_r.no_load;
               `RA_R1:       hr_rdata <= prm_r.r1_pct;
               `RA_X:        hr_rdata <= prm_r.x_pct;
               `RA_GAIN_DRV: hr_rdata <= prm_r.gain_drv;
               `RA_RESP:     hr_rdata <= prm_r.resp;
               `RA_GAIN_BRK: hr_rdata <= prm_r.gain_brk;
               `RA_SLIP:     hr_rdata <= prm_r.slip;
               `RA_MODE:     hr_rdata <= prm_r.mode;
               `RA_START_F:  hr_rdata <= prm_r.start_freq;
               `RA_DELAY:    hr_rdata <= prm_r.delay;
               `RA_CONT_LVL: hr_rdata <= prm_r.cont_level;
               default:      hr_rdata <= 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         params <= '0;
      else if (ce)
         params <= prm_r;
   end
   // restart delay runs from the moment of failure, in 0.1 s steps
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre_r   <= 32'h0000_0000;
         ticks_r <= 16'h0000;
      end
      else if (ce)
      begin
         if (state_r == motor_pkg::ST_NORMAL)
         begin
            pre_r   <= 32'h0000_0000;
            ticks_r <= 16'h0000;
         end
         else if (!delay_done)
         begin
            if (pre_r == DELAY_STEP_CYC - 1)
            begin
               pre_r   <= 32'h0000_0000;
               ticks_r <= ticks_r + 16'h0001;
            end
            else
               pre_r <= pre_r + 32'h0000_0001;
         end
      end
   end
   assign delay_done = (ticks_r >= prm_r.delay);
   // two second run window opens when the supply is back
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         win_r <= 32'h0000_0000;
      else if (ce)
      begin
         if (state_r != motor_pkg::ST_WAIT_RUN)
            win_r <= 32'h0000_0000;
         else
            win_r <= win_r + 32'h0000_0001;
      end
   end
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         motor_pkg::ST_NORMAL:
         begin
            case (prm_r.mode)
               `MODE_TRIP:
                  if (uv)
                     state_nxt = motor_pkg::ST_TRIP;
               `MODE_DECEL:
                  if (dc_link_volts < prm_r.cont_level)
                     state_nxt = motor_pkg::ST_DECEL;
               `MODE_TRIP_R,
               `MODE_SAVED,
               `MODE_START:
                  if (uv)
                     state_nxt = motor_pkg::ST_OUTAGE;
               default:
                  state_nxt = motor_pkg::ST_NORMAL;
            endcase
         end
         motor_pkg::ST_DECEL:
            if (decel_done)
               state_nxt = motor_pkg::ST_TRIP;
         motor_pkg::ST_OUTAGE:
            if (pwr_ok && !uv)
            begin
               if (prm_r.mode == `MODE_TRIP_R)
                  state_nxt = motor_pkg::ST_TRIP;
               else
                  state_nxt = motor_pkg::ST_WAIT_RUN;
            end
         motor_pkg::ST_WAIT_RUN:
            if (uv)
               state_nxt = motor_pkg::ST_OUTAGE;
            else if (run && delay_done)
               state_nxt = motor_pkg::ST_NORMAL;
            else if (win_r >= RUN_WAIT_CYC - 1)
               state_nxt = motor_pkg::ST_NORMAL;
         motor_pkg::ST_TRIP:
            if (alarm_clear && !uv)
               state_nxt = motor_pkg::ST_NORMAL;
         default:
            state_nxt = motor_pkg::ST_NORMAL;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= motor_pkg::ST_NORMAL;
      else if (ce)
         state_r <= state_nxt;
   end
   // frequency at the moment of the sag, kept for a mode 4 restart
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         saved_freq_r <= 16'h0000;
      else if (ce && state_r == motor_pkg::ST_NORMAL && state_nxt == motor_pkg::ST_OUTAGE)
         saved_freq_r <= output_freq;
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         drive_en           <= 1'b0;
         decel_req          <= 1'b0;
         restart_pulse      <= 1'b0;
         restart_freq       <= 16'h0000;
         undervoltage_alarm <= 1'b0;
      end
      else if (ce)
      begin
         restart_pulse      <= 1'b0;
         drive_en           <= (state_nxt == motor_pkg::ST_NORMAL) ||
                               (state_nxt == motor_pkg::ST_DECEL);
         decel_req          <= (state_nxt == motor_pkg::ST_DECEL);
         undervoltage_alarm <= (state_nxt == motor_pkg::ST_TRIP);
         if (state_r == motor_pkg::ST_WAIT_RUN && state_nxt == motor_pkg::ST_NORMAL)
         begin
            if (run && delay_done)
            begin
               restart_pulse <= 1'b1;
               if (prm_r.mode == `MODE_SAVED)
                  restart_freq <= saved_freq_r;
               else
                  restart_freq <= prm_r.start_freq;
            end
            else
               restart_freq <= prm_r.start_freq;
         end
      end
   end
endmodule // motor_param_power_loss_restart
`default_nettype wire

// ==== core/motor_consts.svh ====
`ifndef MOTOR_CONSTS_SVH
`define MOTOR_CONSTS_SVH
`define RA_CAP      16'h0201
`define RA_CUR      16'h0202
`define RA_TUNE     16'h0203
`define RA_NOLOAD   16'h0204
`define RA_R1       16'h0205
`define RA_X        16'h0206
`define RA_GAIN_DRV 16'h0207
`define RA_RESP     16'h0208
`define RA_GAIN_BRK 16'h0209
`define RA_SLIP     16'h020a
`define RA_MODE     16'h000c
`define RA_START_F  16'h0012
`define RA_DELAY    16'h0319
`define RA_CONT_LVL 16'h031b
`define CAP_MIN     16'h0001
`define CAP_MAX     16'h0bb8
`define CUR_MAX     16'h2710
`define TUNE_MAX    16'h0001
`define MEAS_MAX    16'h1388
`define GAIN_MAX    16'h07d0
`define RESP_MIN    16'h0001
`define RESP_MAX    16'h03e8
`define SLIP_MAX    16'h05dc
`define MODE_MAX    16'h0005
`define MODE_HOLE   16'h0003
`define SF_MIN      16'h0001
`define SF_MAX      16'h0258
`define DLY_MIN     16'h0001
`define DLY_MAX     16'h0064
`define LVL_MIN     16'h00c8
`define LVL_MAX     16'h012c
`define RST_CAP     16'h0028
`define RST_CUR     16'h00d2
`define RST_TUNE    16'h0000
`define RST_NOLOAD  16'h0098
`define RST_R1      16'h034f
`define RST_X       16'h046e
`define RST_GAIN    16'h03e8
`define RST_RESP    16'h0064
`define RST_SLIP    16'h00f0
`define RST_MODE    16'h0001
`define RST_START_F 16'h000a
`define RST_DELAY   16'h0005
`define RST_LVL     16'h00eb
`define MODE_TRIP   16'h0000
`define MODE_TRIP_R 16'h0001
`define MODE_DECEL  16'h0002
`define MODE_SAVED  16'h0004
`define MODE_START  16'h0005
`define MCLK_KHZ    250000
`define DELAY_STEP_MS 100
`define RUN_WAIT_MS 2000
`endif

// ==== core/motor_pkg.sv ====
package motor_pkg;
   typedef struct packed {
      logic [15:0] capacity;
      logic [15:0] current;
      logic [15:0] tune;
      logic [15:0] no_load;
      logic [15:0] r1_pct;
      logic [15:0] x_pct;
      logic [15:0] gain_drv;
      logic [15:0] resp;
      logic [15:0] gain_brk;
      logic [15:0] slip;
      logic [15:0] mode;
      logic [15:0] start_freq;
      logic [15:0] delay;
      logic [15:0] cont_level;
   } motor_params_t;
   typedef struct packed {
      logic [15:0] no_load;
      logic [15:0] r1_pct;
      logic [15:0] x_pct;
      logic [15:0] slip;
   } tune_result_t;
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_DECEL,
      ST_OUTAGE,
      ST_WAIT_RUN,
      ST_TRIP
   } loss_state_t;
endpackage

// ==== verification/motor_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    tune_start,
   input  wire logic                    decel_req,
   output var  logic                    tune_done,
   output var  logic                    decel_done,
   output var  motor_pkg::tune_result_t tune_result
);
   logic [4:0] t_cnt_r;
   logic [4:0] d_cnt_r;
   // outside the done pulse the result bus carries inverted junk, never stale data
   assign tune_result = tune_done ? 64'h0111_0222_0333_0444 : 64'hfeee_fddd_fccc_fbbb;
   assign tune_done   = (t_cnt_r == 5'h01);
   assign decel_done  = decel_req && (d_cnt_r == 5'h01);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         t_cnt_r <= 5'h00;
      else if (tune_start)
         t_cnt_r <= 5'h14;
      else if (t_cnt_r != 5'h00)
         t_cnt_r <= t_cnt_r - 5'h01;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         d_cnt_r <= 5'h0a;
      else if (!decel_req)
         d_cnt_r <= 5'h0a;
      else if (d_cnt_r != 5'h01)
         d_cnt_r <= d_cnt_r - 5'h01;
   end
endmodule // motor_stage_model
`default_nettype wire

// ==== verification/motor_plr_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "motor_consts.svh"
module motor_plr_sva #(
   parameter int unsigned DELAY_STEP_CYC = 10,
   parameter int unsigned RUN_WAIT_CYC   = 50
) (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire logic                    ce,
   input wire logic [15:0]             hr_addr,
   input wire logic                    hr_wr,
   input wire logic                    hr_rd,
   input wire logic [15:0]             hr_wdata,
   input wire logic                    hr_ack,
   input wire logic                    hr_err,
   input wire logic                    drive_en,
   input wire logic                    decel_req,
   input wire logic                    restart_pulse,
   input wire logic [15:0]             restart_freq,
   input wire logic                    undervoltage_alarm,
   input wire logic                    tune_start,
   input wire motor_pkg::motor_params_t params
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   AST_ACK_TAKEN: assert property (ce && (hr_wr || hr_rd) |=> hr_ack)
      else $error("no ack one cycle after a request");
   AST_ERR_CAP: assert property (ce && hr_wr && hr_addr == `RA_CAP &&
      (hr_wdata < `CAP_MIN || hr_wdata > `CAP_MAX) |=> hr_ack && hr_err)
      else $error("capacity out of range accepted");
   AST_ERR_MODE: assert property (ce && hr_wr && hr_addr == `RA_MODE &&
      (hr_wdata == `MODE_HOLE || hr_wdata > `MODE_MAX) |=> hr_err)
      else $error("illegal mode accepted");
   AST_KEEP: assert property (hr_ack && hr_err |=> $stable(params))
      else $error("refused write changed the bank");
   AST_MODE0: assert property (params.mode == `MODE_TRIP && $fell(drive_en) |-> undervoltage_alarm)
      else $error("mode 0 cut output without alarm");
   AST_MODE1: assert property (params.mode == `MODE_TRIP_R && $fell(drive_en) |-> !undervoltage_alarm)
      else $error("mode 1 alarmed at sag");
   AST_MODE1_COAST: assert property (params.mode == `MODE_TRIP_R && $rose(undervoltage_alarm) |-> !drive_en)
      else $error("mode 1 alarm while driving");
   AST_DECEL: assert property (params.mode == `MODE_DECEL && $fell(decel_req)
      |-> undervoltage_alarm && !drive_en)
      else $error("decel end without alarm and cut");
   AST_START_F: assert property (restart_pulse && params.mode == `MODE_START
      |-> restart_freq == params.start_freq)
      else $error("mode 5 restart not at start frequency");
   AST_PULSE: assert property (restart_pulse |-> drive_en ##1 !restart_pulse)
      else $error("restart pulse malformed");
   AST_TUNE: assert property (ce && hr_wr && hr_addr == `RA_TUNE && hr_wdata == `TUNE_MAX
      |-> ##[1:2] tune_start)
      else $error("tuning write did not start measurement");
   cover property (restart_pulse);
   cover property ($rose(decel_req));
   cover property (hr_ack && hr_err);
   cover property (tune_start);
endmodule // motor_plr_sva
bind motor_param_power_loss_restart motor_plr_sva #(
   .DELAY_STEP_CYC(DELAY_STEP_CYC),
   .RUN_WAIT_CYC  (RUN_WAIT_CYC)
) motor_plr_sva_i (
   .mclk(mclk), .rst_n(rst_n), .ce(ce), .hr_addr(hr_addr), .hr_wr(hr_wr), .hr_rd(hr_rd),
   .hr_wdata(hr_wdata), .hr_ack(hr_ack), .hr_err(hr_err), .drive_en(drive_en),
   .decel_req(decel_req), .restart_pulse(restart_pulse), .restart_freq(restart_freq),
   .undervoltage_alarm(undervoltage_alarm), .tune_start(tune_start), .params(params)
);
`default_nettype wire

// ==== verification/motor_param_power_loss_restart_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module motor_param_power_loss_restart_tb_top;
   localparam int STEP = 10;
   localparam int WIN  = 50;
   logic                    mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, hr_wr = 1'b0, hr_rd = 1'b0;
   logic                    dc_undervolt = 1'b0, power_ready = 1'b0, run_cmd = 1'b0, alarm_clear = 1'b0;
   logic [15:0]             hr_addr = 16'h0000, hr_wdata = 16'h0000;
   logic [15:0]             dc_link_volts = 16'h00f0, output_freq = 16'h0000;
   logic [15:0]             hr_rdata, restart_freq;
   logic                    hr_ack, hr_err, decel_done, tune_done, drive_en, decel_req;
   logic                    restart_pulse, undervoltage_alarm, tune_start, tune_busy;
   motor_pkg::tune_result_t tune_result;
   int                      n_errors = 0, n_checks = 0, cyc = 0, n_rst = 0, n_tun = 0, n, i;
   logic [15:0]             m;
   logic [15:0] ra [14] = '{16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0205, 16'h0206, 16'h0207,
      16'h0208, 16'h0209, 16'h020a, 16'h000c, 16'h0012, 16'h0319, 16'h031b};
   logic [15:0] rv [14] = '{16'h0028, 16'h00d2, 16'h0000, 16'h0098, 16'h034f, 16'h046e, 16'h03e8,
      16'h0064, 16'h03e8, 16'h00f0, 16'h0001, 16'h000a, 16'h0005, 16'h00eb};
   logic [15:0] ga [6] = '{16'h0201, 16'h0202, 16'h0207, 16'h0208, 16'h0209, 16'h020a};
   logic [15:0] gm [6] = '{16'h0bb8, 16'h2710, 16'h07d0, 16'h03e8, 16'h07d0, 16'h05dc};
   logic [15:0] md [5] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0005};
   motor_param_power_loss_restart #(.DELAY_STEP_CYC(STEP), .RUN_WAIT_CYC(WIN)) motor_param_power_loss_restart_i (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .hr_addr(hr_addr), .hr_wr(hr_wr), .hr_rd(hr_rd),
      .hr_wdata(hr_wdata), .hr_rdata(hr_rdata), .hr_ack(hr_ack), .hr_err(hr_err),
      .dc_undervolt(dc_undervolt), .power_ready(power_ready), .run_cmd(run_cmd),
      .dc_link_volts(dc_link_volts), .output_freq(output_freq), .decel_done(decel_done),
      .alarm_clear(alarm_clear), .tune_done(tune_done), .tune_result(tune_result),
      .drive_en(drive_en), .decel_req(decel_req), .restart_pulse(restart_pulse),
      .restart_freq(restart_freq), .undervoltage_alarm(undervoltage_alarm),
      .tune_start(tune_start), .tune_busy(tune_busy), .params());
   motor_stage_model motor_stage_model_i (
      .mclk(mclk), .rst_n(rst_n), .tune_start(tune_start), .decel_req(decel_req),
      .tune_done(tune_done), .decel_done(decel_done), .tune_result(tune_result));
   always #2 mclk = ~mclk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hangs are cut here rather than left to the simulator
   always @(posedge mclk)
   begin
      cyc++;
      if (restart_pulse === 1'b1)
         n_rst++;
      if (tune_start === 1'b1)
         n_tun++;
      if (cyc == 30000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] d, input logic err);
      hr_rd = rd;
      hr_wr = !rd;
      hr_addr = a;
      hr_wdata = d;
      step(1);
      hr_rd = 1'b0;
      hr_wr = 1'b0;
      // the answer stands for one cycle only, so look at it now
      chk(16'(hr_ack), 16'h0001);
      chk(16'(hr_err), 16'(err));
      if (rd && !err)
         chk(hr_rdata, d);
      step(1);
   endtask
   // 0: restart pulse, 1: decel request, 2: alarm
   function automatic logic pick(input int sel);
      pick = (sel == 0) ? restart_pulse : (sel == 1) ? decel_req : undervoltage_alarm;
   endfunction
   // bounded wait; k returns the cycles spent
   task automatic wait_hi(input int sel, output int k);
      k = 0;
      while (pick(sel) !== 1'b1 && k < 400)
      begin
         step(1);
         k++;
      end
      chk(16'(pick(sel)), 16'h0001);
   endtask
   initial
   begin
      step(5);
      rst_n = 1'b1;
      step(3);
      chk(16'(drive_en), 16'h0001);
      for (i = 0; i < 14; i++)
         acc(1'b1, ra[i], rv[i], 1'b0);
      for (i = 0; i < 6; i++)
      begin
         acc(1'b0, ga[i], gm[i], 1'b0);
         acc(1'b0, ga[i], gm[i] + 16'h0001, 1'b1);
         acc(1'b1, ga[i], gm[i], 1'b0);
      end
      acc(1'b0, 16'h0201, 16'h0000, 1'b1);
      acc(1'b0, 16'h0202, 16'h2711, 1'b1);
      acc(1'b0, 16'h020a, 16'h05dd, 1'b1);
      acc(1'b0, 16'h0208, 16'h0000, 1'b1);
      acc(1'b0, 16'h0209, 16'h0000, 1'b0);
      acc(1'b1, 16'h0209, 16'h0000, 1'b0);
      acc(1'b0, 16'h000c, 16'h0003, 1'b1);
      acc(1'b0, 16'h000c, 16'h0006, 1'b1);
      acc(1'b0, 16'h0300, 16'h0001, 1'b1);
      acc(1'b1, 16'h0300, 16'h0000, 1'b1);
      acc(1'b0, 16'h0203, 16'h0002, 1'b1);
      acc(1'b0, 16'h0203, 16'h0001, 1'b0);
      chk(16'(n_tun), 16'h0001);
      chk(16'(tune_busy), 16'h0001);
      step(30);
      chk(16'(tune_busy), 16'h0000);
      for (i = 0; i < 3; i++)
         acc(1'b1, ra[i + 3], 16'h0111 * 16'(i + 1), 1'b0);
      acc(1'b1, 16'h020a, 16'h0444, 1'b0);
      acc(1'b1, 16'h0203, 16'h0000, 1'b0);
      for (i = 0; i < 5; i++)
      begin
         acc(1'b0, 16'h000c, md[i], md[i] == 16'h0003);
         // a refused mode 3 leaves mode 1 in force
         m = (md[i] == 16'h0003) ? 16'h0001 : md[i];
         output_freq = 16'h0100 + m;
         step(3);
         dc_undervolt = 1'b1;
         power_ready = 1'b0;
         step(4);
         chk(16'(drive_en), 16'h0000);
         chk(16'(undervoltage_alarm), 16'(m == 16'h0000));
         output_freq = 16'h0fff;
         step(2);
         dc_undervolt = 1'b0;
         power_ready = 1'b1;
         run_cmd = (m > 16'h0003);
         if (run_cmd)
         begin
            wait_hi(0, n);
            chk(16'(n + 6 >= 5 * STEP), 16'h0001);
            chk(restart_freq, m == 16'h0004 ? 16'h0104 : 16'h000a);
         end
         else
         begin
            step(4);
            chk(16'(undervoltage_alarm), 16'(m < 16'h0002));
            alarm_clear = 1'b1;
            step(1);
            alarm_clear = 1'b0;
            step(3);
         end
         chk(16'(drive_en), 16'h0001);
         run_cmd = 1'b0;
      end
      acc(1'b0, 16'h000c, 16'h0004, 1'b0);
      acc(1'b0, 16'h0012, 16'h0020, 1'b0);
      dc_undervolt = 1'b1;
      power_ready = 1'b0;
      step(6);
      dc_undervolt = 1'b0;
      power_ready = 1'b1;
      n = n_rst;
      step(5 * STEP + WIN + 20);
      chk(16'(n_rst - n), 16'h0000);
      chk(restart_freq, 16'h0020);
      chk(16'(drive_en), 16'h0001);
      acc(1'b0, 16'h000c, 16'h0002, 1'b0);
      dc_link_volts = 16'h00eb;
      step(6);
      chk(16'(decel_req), 16'h0000);
      dc_link_volts = 16'h00ea;
      wait_hi(1, n);
      wait_hi(2, n);
      chk(16'(drive_en), 16'h0000);
      chk(16'(decel_req), 16'h0000);
      dc_link_volts = 16'h00f0;
      alarm_clear = 1'b1;
      step(1);
      alarm_clear = 1'b0;
      step(3);
      chk(16'(undervoltage_alarm), 16'h0000);
      end_of_test();
   end
endmodule // motor_param_power_loss_restart_tb_top
`default_nettype wire
